// File: src/vector_map.sv
`timescale 1ns/1ps
module vector_map (
   // Clock and reset
   input  wire logic                                  core_clk,
   input  wire logic                                  resetn,
   // Peripheral requests, bit i is vector i+2
   input  wire logic [vector_map_pkg::NUM_SRC-1:0]    src_req,
   // Fuse and boot section start, static straps
   input  wire logic                                  boot_reset_fuse,
   input  wire logic [vector_map_pkg::PC_W-1:0]       boot_start_addr,
   // Register port
   input  wire logic [vector_map_pkg::REG_AW-1:0]     reg_addr,
   input  wire logic [vector_map_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                                  reg_wr,
   input  wire logic                                  reg_rd,
   output logic      [vector_map_pkg::DATA_W-1:0]     reg_rdata,
   // Core fetch side
   input  wire logic                                  core_int_enable,
   input  wire logic                                  instr_retire,
   input  wire logic                                  core_ack,
   output vector_map_pkg::dispatch_t                  dispatch,
   output logic      [vector_map_pkg::PC_W-1:0]       reset_vector_addr,
   output logic                                       irq,
   output logic                                       pullup_disable
);
   localparam int N  = vector_map_pkg::NUM_SRC;
   localparam int AW = vector_map_pkg::PC_W;
   localparam int IW = vector_map_pkg::ID_W;

   function automatic logic [IW:0] first_set(input logic [N-1:0] v);
      logic [IW:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, IW'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [AW-1:0] vec_addr(input logic [IW-1:0] id,
                                              input logic          sel,
                                              input logic [AW-1:0] base);
      logic [AW-1:0] off;
      off = vector_map_pkg::VEC_TABLE[id];
      return sel ? AW'(base + off) : off;
   endfunction

   // Reset release
   logic rst_meta_ff;
   logic rst_n;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // Strap synchronisers
   logic          fuse_meta_ff;
   logic          fuse_ff;
   logic [AW-1:0] boot_meta_ff;
   logic [AW-1:0] boot_addr_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fuse_meta_ff <= vector_map_pkg::FUSE_RST;
         fuse_ff      <= vector_map_pkg::FUSE_RST;
         boot_meta_ff <= '0;
         boot_addr_ff <= '0;
      end else begin
         fuse_meta_ff <= boot_reset_fuse;
         fuse_ff      <= fuse_meta_ff;
         boot_meta_ff <= boot_start_addr;
         boot_addr_ff <= boot_meta_ff;
      end
   end

   // Reset entry
   logic [AW-1:0] reset_addr_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_addr_ff <= vector_map_pkg::RESET_ADDR;
      end else if (fuse_ff) begin
         reset_addr_ff <= vector_map_pkg::RESET_ADDR;
      end else begin
         reset_addr_ff <= boot_addr_ff;
      end
   end

   assign reset_vector_addr = reset_addr_ff;

   // Register decode
   logic wr_ctrl;
   logic wr_pend;
   logic wr_mask;
   logic wr_unlock;
   logic wr_select;
   logic unlock_on;

   assign wr_ctrl   = reg_wr && (reg_addr == vector_map_pkg::OFF_CTRL);
   assign wr_pend   = reg_wr && (reg_addr == vector_map_pkg::OFF_PEND);
   assign wr_mask   = reg_wr && (reg_addr == vector_map_pkg::OFF_MASK);
   assign wr_unlock = wr_ctrl && reg_wdata[vector_map_pkg::BIT_UNLOCK];
   assign wr_select = wr_ctrl && !reg_wdata[vector_map_pkg::BIT_UNLOCK]
                      && unlock_on;

   // Unlock window and dispatch block
   vector_map_pkg::unlock_state_t ul_state_ff;
   logic [2:0]                    ul_cnt_ff;
   logic                          blocked;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ul_state_ff <= vector_map_pkg::UL_IDLE;
         ul_cnt_ff   <= '0;
      end else begin
         case (ul_state_ff)
            vector_map_pkg::UL_IDLE: begin
               if (wr_unlock) begin
                  ul_state_ff <= vector_map_pkg::UL_ARMED;
                  ul_cnt_ff   <= vector_map_pkg::UNLOCK_LOAD;
               end
            end
            vector_map_pkg::UL_ARMED: begin
               if (wr_select) begin
                  ul_state_ff <= vector_map_pkg::UL_HOLD;
               end else if (wr_unlock) begin
                  ul_cnt_ff   <= vector_map_pkg::UNLOCK_LOAD;
               end else if (ul_cnt_ff == 3'h0) begin
                  ul_state_ff <= vector_map_pkg::UL_IDLE;
               end else begin
                  ul_cnt_ff   <= ul_cnt_ff - 3'h1;
               end
            end
            vector_map_pkg::UL_HOLD: begin
               if (wr_unlock) begin
                  ul_state_ff <= vector_map_pkg::UL_ARMED;
                  ul_cnt_ff   <= vector_map_pkg::UNLOCK_LOAD;
               end else if (instr_retire) begin
                  ul_state_ff <= vector_map_pkg::UL_IDLE;
               end
            end
            default: begin
               ul_state_ff <= vector_map_pkg::UL_IDLE;
            end
         endcase
      end
   end

   assign unlock_on = (ul_state_ff == vector_map_pkg::UL_ARMED);
   // Blocked from the unlock write itself onward
   assign blocked   = (ul_state_ff != vector_map_pkg::UL_IDLE)
                      || wr_unlock;

   // Control bits
   logic select_ff;
   logic pullup_off_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         select_ff <= 1'b0;
      end else if (wr_select) begin
         select_ff <= reg_wdata[vector_map_pkg::BIT_SELECT];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_off_ff <= 1'b0;
      end else if (wr_ctrl) begin
         pullup_off_ff <= reg_wdata[vector_map_pkg::BIT_PULLUP_OFF];
      end
   end

   assign pullup_disable = pullup_off_ff;

   // Pending and mask
   logic [N-1:0]  pending_ff;
   logic [N-1:0]  mask_ff;
   logic [N-1:0]  nxt_pending;
   logic [N-1:0]  nxt_mask;
   logic [N-1:0]  ack_clr;
   logic          dsp_found_ff;
   logic [IW-1:0] dsp_id_ff;
   logic [AW-1:0] dsp_addr_ff;
   logic [IW:0]   nxt_first;
   logic          irq_ff;

   assign ack_clr = (core_ack && dispatch.valid)
                    ? (N'(1) << dsp_id_ff) : '0;

   always_comb begin
      nxt_mask    = wr_mask ? reg_wdata[N-1:0] : mask_ff;
      // New requests win over clears
      nxt_pending = pending_ff;
      if (wr_pend) begin
         nxt_pending = nxt_pending & ~reg_wdata[N-1:0];
      end
      nxt_pending = (nxt_pending & ~ack_clr) | src_req;
      nxt_first   = first_set(nxt_pending & nxt_mask);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_ff <= '0;
         mask_ff    <= '0;
         irq_ff     <= 1'b0;
      end else begin
         pending_ff <= nxt_pending;
         mask_ff    <= nxt_mask;
         irq_ff     <= |(nxt_pending & nxt_mask);
      end
   end

   assign irq = irq_ff;

   // Vector selection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dsp_found_ff <= 1'b0;
         dsp_id_ff    <= '0;
         dsp_addr_ff  <= '0;
      end else begin
         dsp_found_ff <= nxt_first[IW];
         dsp_id_ff    <= nxt_first[IW-1:0];
         dsp_addr_ff  <= vec_addr(nxt_first[IW-1:0], select_ff,
                                  boot_addr_ff);
      end
   end

   assign dispatch.valid = dsp_found_ff && core_int_enable
                           && !blocked;
   assign dispatch.id    = dsp_id_ff;
   assign dispatch.addr  = dsp_addr_ff;

   // Read port
   logic [vector_map_pkg::DATA_W-1:0] rd_val;
   logic [vector_map_pkg::DATA_W-1:0] rdata_ff;

   always_comb begin
      rd_val = '0;
      case (reg_addr)
         vector_map_pkg::OFF_CTRL: begin
            rd_val[vector_map_pkg::BIT_UNLOCK]     = unlock_on;
            rd_val[vector_map_pkg::BIT_SELECT]     = select_ff;
            rd_val[vector_map_pkg::BIT_PULLUP_OFF] = pullup_off_ff;
         end
         vector_map_pkg::OFF_PEND: rd_val[N-1:0] = pending_ff;
         vector_map_pkg::OFF_MASK: rd_val[N-1:0] = mask_ff;
         vector_map_pkg::OFF_STAT: begin
            rd_val[vector_map_pkg::BIT_BLOCKED] = blocked;
            rd_val[vector_map_pkg::BIT_FUSE]    = fuse_ff;
            rd_val[vector_map_pkg::STAT_BOOT_LSB +: AW] = boot_addr_ff;
         end
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= reg_rd ? rd_val : '0;
      end
   end

   assign reg_rdata = rdata_ff;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic [N-1:0] below_id;
   logic [N-1:0] eligible;
   assign eligible = pending_ff & mask_ff;
   assign below_id = (N'(1) << dsp_id_ff) - N'(1);

   sequence s_arm;
      (ul_state_ff == vector_map_pkg::UL_IDLE) && wr_unlock;
   endsequence

   sequence s_quiet4;
      (!wr_ctrl)[*4];
   endsequence

   sequence s_sel_write;
      wr_select ##1 (ul_state_ff == vector_map_pkg::UL_HOLD);
   endsequence

   a_reset_app: assert property (
      fuse_ff |=> reset_vector_addr == vector_map_pkg::RESET_ADDR)
      else $error("reset entry not zero with fuse unprogrammed");

   a_reset_boot: assert property (
      !fuse_ff |=> reset_vector_addr == $past(boot_addr_ff))
      else $error("reset entry not boot start with fuse programmed");

   a_unlock_expire: assert property (
      s_arm ##1 s_quiet4 |=> ul_state_ff == vector_map_pkg::UL_IDLE)
      else $error("unlock bit outlived four cycles");

   a_unlock_holds: assert property (
      s_arm |=> unlock_on [*4])
      else $error("unlock window shorter than four cycles");

   a_select_gated: assert property (
      $changed(select_ff) |-> $past(wr_select))
      else $error("select changed without unlock sequence");

   a_select_value: assert property (
      wr_select |=> select_ff == $past(reg_wdata[1]) && !unlock_on)
      else $error("select write not taken or unlock not cleared");

   a_block_hold: assert property (
      s_sel_write ##0 !instr_retire
      |-> !dispatch.valid ##1 !dispatch.valid)
      else $error("dispatch during select hold");

   a_block_arm: assert property (
      wr_unlock |-> !dispatch.valid ##1 !dispatch.valid)
      else $error("dispatch while unlock armed");

   a_vec_table: assert property (
      dsp_found_ff && !select_ff && !$past(select_ff)
      |-> dsp_addr_ff == AW'(vector_map_pkg::VEC_BASE
          + AW'(dsp_id_ff) * vector_map_pkg::VEC_STRIDE))
      else $error("vector address off the two-word grid");

   a_vec_boot: assert property (
      dsp_found_ff && select_ff && $past(select_ff)
      && $stable(boot_addr_ff)
      |-> dsp_addr_ff == AW'(boot_addr_ff
          + vector_map_pkg::VEC_TABLE[dsp_id_ff]))
      else $error("relocated vector not offset by boot start");

   a_priority_low: assert property (
      dispatch.valid |-> eligible[dsp_id_ff]
                         && ((eligible & below_id) == '0))
      else $error("lower pending vector skipped");

   a_pend_set: assert property (
      (src_req != '0) |=> (pending_ff & $past(src_req)) == $past(src_req))
      else $error("request lost against a clear");

endmodule

// File: src/vector_map_pkg.sv
// Overview of operation
// - The reset entry is program address 0x0000 while the boot reset fuse is unprogrammed.
// - External requests 0 to 7 use vectors 2 to 9 at 0x0002 to 0x0010.
// - Pin change requests 0 and 1 use 0x0012 and 0x0014.
// - USB general and USB endpoint requests use 0x0016 and 0x0018.
// - Watchdog uses 0x001A, timer 1 capture, compares and overflow 0x001C-0x0024.
// - Timer 0 compares A and B and overflow use 0x0026, 0x0028 and 0x002A.
// - The SPI transfer-complete request uses 0x002C.
// - Serial receive, buffer-empty and transmit-done use 0x002E, 0x0030, 0x0032.
// - Comparator, EEPROM-ready and store-ready use 0x0034, 0x0036, 0x0038.
// - With the table select set, each vector adds the boot section start.
// - Vector entries stay two program words apart in every flash size.
// - A programmed boot reset fuse moves the reset entry to the boot start.
// - Reset at 0x0000 or boot start; vectors from 0x0002 or boot start + 2.
// - The boot reset fuse reads 1 unprogrammed and 0 programmed.
// - Select changes only by an unlock write then a select write within four.
// - Unlock clears after four cycles or on select write; dispatch is blocked.
package vector_map_pkg;
   localparam int PC_W              = 16;
   localparam int NUM_SRC           = 28;
   localparam int ID_W              = 5;
   localparam int DATA_W            = 32;
   localparam int REG_AW            = 8;
   // Register map
   localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] OFF_PEND = 8'h04;
   localparam logic [REG_AW-1:0] OFF_MASK = 8'h08;
   localparam logic [REG_AW-1:0] OFF_STAT = 8'h0C;
   // Control and status fields
   localparam int BIT_UNLOCK        = 0;
   localparam int BIT_SELECT        = 1;
   localparam int BIT_PULLUP_OFF    = 4;
   localparam int BIT_BLOCKED       = 0;
   localparam int BIT_FUSE          = 1;
   localparam int STAT_BOOT_LSB     = 16;
   // Addresses and timing
   localparam logic [PC_W-1:0] RESET_ADDR = 16'h0000;
   localparam logic [PC_W-1:0] VEC_BASE   = 16'h0002;
   localparam logic [PC_W-1:0] VEC_STRIDE = 16'h0002;
   localparam logic            FUSE_RST   = 1'b1;
   localparam int UNLOCK_WINDOW_CYC = 4;
   localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_WINDOW_CYC - 1);
   // Source i sits at vector i+2, two words apart
   localparam logic [PC_W-1:0] VEC_TABLE [NUM_SRC] = '{
      16'h0002, 16'h0004, 16'h0006, 16'h0008,
      16'h000A, 16'h000C, 16'h000E, 16'h0010,
      16'h0012, 16'h0014,
      16'h0016, 16'h0018,
      16'h001A, 16'h001C, 16'h001E, 16'h0020,
      16'h0022, 16'h0024,
      16'h0026, 16'h0028, 16'h002A,
      16'h002C,
      16'h002E, 16'h0030, 16'h0032,
      16'h0034, 16'h0036, 16'h0038
   };
   typedef enum {UL_IDLE, UL_ARMED, UL_HOLD} unlock_state_t;
   typedef struct packed {
      logic            valid;
      logic [ID_W-1:0] id;
      logic [PC_W-1:0] addr;
   } dispatch_t;
endpackage

// File: verification/core_model.sv
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   // Vector offer and acknowledge
   input  wire vector_map_pkg::dispatch_t dispatch,
   input  wire logic [3:0]                ack_delay,
   output logic                           core_ack,
   // Vector taken, one cycle
   output logic                           taken,
   output logic [4:0]                     taken_id,
   output logic [15:0]                    taken_addr
);
   logic [3:0] wait_ff;

   // Acks once the offer has stood ack_delay+1 cycles
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         core_ack   <= 1'b0;
         taken      <= 1'b0;
         taken_id   <= 5'h0;
         taken_addr <= 16'h0000;
         wait_ff    <= 4'h0;
      end else begin
         taken <= core_ack & dispatch.valid;
         if (core_ack & dispatch.valid) begin
            taken_id   <= dispatch.id;
            taken_addr <= dispatch.addr;
         end
         if (core_ack | !dispatch.valid) begin
            core_ack <= 1'b0;
            wait_ff  <= 4'h0;
         end else if (wait_ff >= ack_delay) begin
            core_ack <= 1'b1;
         end else begin
            wait_ff <= wait_ff + 4'h1;
         end
      end
   end
endmodule

// File: verification/vector_map_tb.sv
`timescale 1ns/1ps
module vector_map_tb;
   localparam logic [15:0] BOOT_START = 16'h1C00;
   logic                      core_clk;
   logic                      resetn;
   logic [27:0]               src_req;
   logic                      boot_reset_fuse;
   logic [7:0]                reg_addr;
   logic [31:0]               reg_wdata;
   logic                      reg_wr;
   logic                      reg_rd;
   logic [31:0]               reg_rdata;
   logic                      core_int_enable;
   logic                      instr_retire;
   logic                      core_ack;
   vector_map_pkg::dispatch_t dispatch;
   logic [15:0]               reset_vector_addr;
   logic                      irq;
   logic                      pullup_disable;
   logic [3:0]                ack_delay;
   logic                      taken;
   logic [4:0]                taken_id;
   logic [15:0]               taken_addr;
   logic [31:0]               rdv;
   logic [4:0]                tid;
   logic [15:0]               ta;
   int                        fail_count;
   int                        total_checks;

   vector_map u_vector_map (
      .core_clk, .resetn, .src_req, .boot_reset_fuse,
      .boot_start_addr(BOOT_START), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .core_int_enable, .instr_retire, .core_ack,
      .dispatch, .reset_vector_addr, .irq, .pullup_disable
   );
   core_model u_core_model (
      .core_clk, .resetn, .dispatch, .ack_delay, .core_ack, .taken,
      .taken_id, .taken_addr
   );

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic pulse_req(input logic [27:0] m);
      @(posedge core_clk);
      src_req <= m;
      @(posedge core_clk);
      src_req <= '0;
   endtask

   task automatic retire;
      @(posedge core_clk);
      instr_retire <= 1'b1;
      @(posedge core_clk);
      instr_retire <= 1'b0;
   endtask

   task automatic take(output logic [4:0] id, output logic [15:0] a);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (taken !== 1'b1 && n < 60);
      id = (taken === 1'b1) ? taken_id : 'x;
      a  = (taken === 1'b1) ? taken_addr : 'x;
   endtask

   task automatic no_take(input int n);
      logic seen_v;
      seen_v = 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         #1;
         seen_v = seen_v | dispatch.valid;
      end
      check(32'(seen_v), 32'h0);
   endtask

   task automatic do_reset(input logic fuse);
      @(posedge core_clk);
      boot_reset_fuse <= fuse;
      resetn          <= 1'b0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (10) @(posedge core_clk);
   endtask

   task automatic t_reset;
      check(32'(reset_vector_addr), 32'h0);
      bus_rd(vector_map_pkg::OFF_STAT, rdv);
      check(rdv, {BOOT_START, 16'h0002});
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h0);
      bus_rd(8'h40, rdv);
      check(rdv, 32'h0);
      // Pull-up bit follows every control write, select stays locked
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h12);
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h10);
      check(32'(pullup_disable), 32'h1);
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h0);
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h0);
      check(32'(pullup_disable), 32'h0);
      $display("Reset test done");
   endtask

   task automatic t_table(input logic [15:0] vb);
      logic [15:0] ex;
      for (int i = 0; i < 28; i++) begin
         pulse_req(28'h1 << i);
         take(tid, ta);
         ex = vb + 16'(2 * i + 2);
         check(32'(tid), 32'(i));
         check(32'(ta), 32'(ex));
      end
      $display("Vector table test done");
   endtask

   task automatic t_priority;
      ack_delay <= 4'h3;
      pulse_req(28'h810_0020);
      take(tid, ta);
      check(32'(tid), 32'h5);
      take(tid, ta);
      check(32'(tid), 32'h14);
      take(tid, ta);
      check(32'(tid), 32'h1B);
      ack_delay <= 4'h0;
      $display("Priority test done");
   endtask

   task automatic t_mask;
      @(posedge core_clk);
      core_int_enable <= 1'b0;
      bus_wr(vector_map_pkg::OFF_MASK, 32'h0FFF_FFEF);
      pulse_req(28'h10);
      bus_rd(vector_map_pkg::OFF_PEND, rdv);
      check(rdv, 32'h10);
      check(32'(irq), 32'h0);
      bus_wr(vector_map_pkg::OFF_MASK, 32'h0FFF_FFFF);
      no_take(3);
      check(32'(irq), 32'h1);
      bus_wr(vector_map_pkg::OFF_PEND, 32'h10);
      repeat (2) @(posedge core_clk);
      #1;
      check(32'(irq), 32'h0);
      @(posedge core_clk);
      core_int_enable <= 1'b1;
      $display("Mask test done");
   endtask

   task automatic t_select;
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h1);
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h1);
      // Select write lands in the last cycle of the window
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h2);
      pulse_req(28'h1);
      no_take(6);
      bus_rd(vector_map_pkg::OFF_STAT, rdv);
      check(rdv, {BOOT_START, 16'h0003});
      retire();
      take(tid, ta);
      check(32'(ta), 32'(BOOT_START + 16'h0002));
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h2);
      $display("Select test done");
   endtask

   task automatic t_late;
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h1);
      repeat (6) @(posedge core_clk);
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h2);
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h0);
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h2);
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h1);
      bus_wr(vector_map_pkg::OFF_CTRL, 32'h0);
      retire();
      bus_rd(vector_map_pkg::OFF_CTRL, rdv);
      check(rdv, 32'h0);
      pulse_req(28'h2);
      take(tid, ta);
      check(32'(ta), 32'h4);
      $display("Late select test done");
   endtask

   task automatic t_fuse;
      do_reset(1'b0);
      check(32'(reset_vector_addr), 32'(BOOT_START));
      bus_rd(vector_map_pkg::OFF_STAT, rdv);
      check(rdv, {BOOT_START, 16'h0000});
      $display("Fuse test done");
   endtask

   initial begin
      resetn          = 1'b0;
      boot_reset_fuse = 1'b1;
      src_req         = '0;
      reg_addr        = '0;
      reg_wdata       = '0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      core_int_enable = 1'b1;
      instr_retire    = 1'b0;
      ack_delay       = 4'h0;
      fail_count      = 0;
      total_checks    = 0;
      do_reset(1'b1);
      t_reset();
      bus_wr(vector_map_pkg::OFF_MASK, 32'h0FFF_FFFF);
      t_table(16'h0000);
      t_priority();
      t_mask();
      t_select();
      t_table(BOOT_START);
      t_late();
      t_fuse();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      test_done();
   end
endmodule
